// file: src/sdcl_device.sv
// Purpose: Divider configuration front end of the synthesizer
// Assumes: Pins synchronous to sys_clk_in; VCO modelled by a tick input
// Notes: Divider moduli change only at a counter wrap
// Summary of operation
// - Parallel strobe rise captures loop and output dividers
// - Parallel latches transparent while strobe low
// - Serial bits shift into 14-bit register
// - Stream order: test, output, loop bits
// - Each field sent most significant bit first
// - Controller keeps parallel strobe high when serial
// - Serial strobe pulsed after all bits shifted
// - Serial strobe falling edge latches dividers
// - Test bits settable only through serial stream
// - Parallel strobe low forces test bits zero
// - Test pin follows eight-way test select
// - Select 110 bypasses PLL with shift clock
// - Bypass routes loop counter to test pin
// - Loop counter output duty not fifty percent
// - Output divider goes down to ratio one
// - Reset test latch shows first shifted bit
// - Shift clock at most 10MHz for loading
// - Parallel setup at power-up, serial later
// - Frequency steps of 1MHz or less
// - Serial data sampled on shift clock rise
// - Serial latches transparent while serial strobe high
// - Loop divider bit 8 is most significant
// - Output codes give moduli one, two, four, eight
`timescale 1ns/1ps
`default_nettype none
module sdcl_device (
   input wire logic sys_clk_in,
   input wire logic srst_in,
   sdcl_if.dev link,
   input wire logic reference_input_clock_in,
   input wire logic vco_tick_in,
   output logic [8:0] cfg_loop_out,
   output logic [1:0] cfg_out_div_out,
   output logic [2:0] cfg_test_out,
   output logic bypass_out,
   output logic loop_counter_output_out
);
   // Output divider modulus for a two-bit code
   function automatic logic [3:0] out_modulus(input logic [1:0] code);
      logic [3:0] m;
      m = 4'h1;
      case (code)
         sdcl_pkg::N_CODE_DIV2: m = 4'h2;
         sdcl_pkg::N_CODE_DIV4: m = 4'h4;
         sdcl_pkg::N_CODE_DIV8: m = 4'h8;
         default: m = 4'h1;
      endcase
      return m;
   endfunction

   // True when a counter sits on its last count; modulus 0 acts as 1
   function automatic logic last_count(input logic [8:0] cnt,
                                       input logic [8:0] modv);
      return ({1'b0, cnt} + 10'h001) >= {1'b0, modv};
   endfunction

   logic sclk_prev_q;
   logic [13:0] shift_q;
   logic [8:0] cfg_m_q;
   logic [1:0] cfg_n_q;
   logic [2:0] cfg_t_q;
   logic [8:0] loop_cnt_q;
   logic [8:0] loop_mod_q;
   logic loop_pulse_q;
   logic [3:0] out_cnt_q;
   logic [3:0] out_mod_q;
   logic [1:0] pair_q;
   logic [1:0] quarter_q;
   logic pair4_q;
   logic ref_q;
   logic test_q;
   logic sclk_rise;
   logic sclk_edge;
   logic bypass;
   logic div_tick;

   // Shift clock edges seen at the system clock
   assign sclk_rise = link.shift_clock_alias & ~sclk_prev_q;
   assign sclk_edge = link.shift_clock_alias ^ sclk_prev_q;
   assign bypass = cfg_t_q == sdcl_pkg::SDCL_TST_BYPASS;
   // Both shift clock edges drive dividers in bypass so ratio 1 passes it
   assign div_tick = bypass ? sclk_edge : vco_tick_in;

   // Previous shift clock level for edge detection
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         sclk_prev_q <= 1'b0;
      end
      else
      begin
         sclk_prev_q <= link.shift_clock_alias;
      end
   end

   // Serial shift register, disabled while the parallel strobe is low
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         shift_q <= 14'h0000;
      end
      else if (link.par_load && sclk_rise)
      begin
         // Newest bit enters at the bottom, first bit ends at the top
         shift_q <= {shift_q[12:0], link.ser_data};
      end
   end

   // Configuration latches: parallel transparent low, serial high
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         cfg_m_q <= sdcl_pkg::M_RST;
         cfg_n_q <= sdcl_pkg::N_RST;
         cfg_t_q <= sdcl_pkg::T_RST;
      end
      else if (!link.par_load)
      begin
         // Last value before the strobe rise is what stays held
         cfg_m_q <= link.loop_div;
         cfg_n_q <= link.out_div;
         cfg_t_q <= sdcl_pkg::T_RST;
      end
      else if (link.ser_load)
      begin
         // Transparent while high; value at the falling edge stays
         cfg_m_q <= shift_q[sdcl_pkg::M_LSB +: sdcl_pkg::M_W];
         cfg_n_q <= shift_q[sdcl_pkg::N_LSB +: sdcl_pkg::N_W];
         cfg_t_q <= shift_q[sdcl_pkg::T_LSB +: sdcl_pkg::T_W];
      end
   end

   // Loop counter; new modulus taken only at wrap to avoid runts
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         loop_cnt_q <= 9'h000;
         loop_mod_q <= sdcl_pkg::M_RST;
         loop_pulse_q <= 1'b0;
      end
      else if (div_tick)
      begin
         if (last_count(loop_cnt_q, loop_mod_q))
         begin
            loop_cnt_q <= 9'h000;
            loop_mod_q <= cfg_m_q;
            loop_pulse_q <= 1'b1;
         end
         else
         begin
            loop_cnt_q <= loop_cnt_q + 9'h001;
            loop_pulse_q <= 1'b0;
         end
      end
   end

   // Output divider; pair toggles once per modulus ticks
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         out_cnt_q <= 4'h0;
         out_mod_q <= out_modulus(sdcl_pkg::N_RST);
         pair_q <= 2'h2;
      end
      else if (div_tick)
      begin
         if (last_count({5'h00, out_cnt_q}, {5'h00, out_mod_q}))
         begin
            out_cnt_q <= 4'h0;
            out_mod_q <= out_modulus(cfg_n_q);
            pair_q <= ~pair_q;
         end
         else
         begin
            out_cnt_q <= out_cnt_q + 4'h1;
         end
      end
   end

   // Quarter-rate copy of the output, for the test pin
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         quarter_q <= 2'h0;
         pair4_q <= 1'b0;
      end
      else if (div_tick && last_count({5'h00, out_cnt_q}, {5'h00, out_mod_q}))
      begin
         quarter_q <= quarter_q + 2'h1;
         if (quarter_q == 2'h3)
         begin
            pair4_q <= ~pair4_q;
         end
      end
   end

   // Reference sampled once so the test pin comes from a flip-flop
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         ref_q <= 1'b0;
      end
      else
      begin
         ref_q <= reference_input_clock_in;
      end
   end

   // Test pin selection; any activity here costs output jitter
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         test_q <= 1'b0;
      end
      else
      begin
         case (sdcl_pkg::sdcl_test_e'(cfg_t_q))
            sdcl_pkg::SDCL_TST_SHIFT: test_q <= shift_q[13];
            sdcl_pkg::SDCL_TST_HIGH: test_q <= 1'b1;
            sdcl_pkg::SDCL_TST_REF: test_q <= ref_q;
            sdcl_pkg::SDCL_TST_LOOP: test_q <= loop_pulse_q;
            sdcl_pkg::SDCL_TST_PAIR: test_q <= pair_q[0];
            sdcl_pkg::SDCL_TST_LOW: test_q <= 1'b0;
            sdcl_pkg::SDCL_TST_BYPASS: test_q <= loop_pulse_q;
            default: test_q <= pair4_q;
         endcase
      end
   end

   // Pins and observation outputs, all from flip-flops
   assign link.test_pin = test_q;
   assign link.synth_output_pair = pair_q;
   assign cfg_loop_out = cfg_m_q;
   assign cfg_out_div_out = cfg_n_q;
   assign cfg_test_out = cfg_t_q;
   assign loop_counter_output_out = loop_pulse_q;

   // Registered bypass flag
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         bypass_out <= 1'b0;
      end
      else
      begin
         bypass_out <= bypass;
      end
   end
endmodule
`default_nettype wire

// file: src/sdcl_pkg.sv
// Purpose: Shared constants for the synthesizer divider config loader
// Assumes: 100 MHz system clock, all pins synchronous to it
// Notes: Stream layout is test bits, output divider bits, loop bits
package sdcl_pkg;
   // Field widths and stream layout, most significant field first
   localparam int M_W = 9;
   localparam int N_W = 2;
   localparam int T_W = 3;
   localparam int SHIFT_LEN = 14;
   localparam int M_LSB = 0;
   localparam int N_LSB = 9;
   localparam int T_LSB = 11;

   // Reset values mirror pulled-up parallel pins
   localparam logic [8:0] M_RST = 9'h01ff;
   localparam logic [1:0] N_RST = 2'h3;
   localparam logic [2:0] T_RST = 3'h0;

   // Test output selections
   typedef enum logic [2:0] {
      SDCL_TST_SHIFT = 3'h0,
      SDCL_TST_HIGH = 3'h1,
      SDCL_TST_REF = 3'h2,
      SDCL_TST_LOOP = 3'h3,
      SDCL_TST_PAIR = 3'h4,
      SDCL_TST_LOW = 3'h5,
      SDCL_TST_BYPASS = 3'h6,
      SDCL_TST_PAIR_DIV4 = 3'h7
   } sdcl_test_e;

   // Output divider codes
   localparam logic [1:0] N_CODE_DIV2 = 2'h0;
   localparam logic [1:0] N_CODE_DIV4 = 2'h1;
   localparam logic [1:0] N_CODE_DIV8 = 2'h2;
   localparam logic [1:0] N_CODE_DIV1 = 2'h3;

   // Timing, in ns, and derived cycle counts
   localparam int SYS_PERIOD_NS = 10;
   localparam int SCLK_MIN_PERIOD_NS = 100;
   localparam int SETUP_NS = 20;
   localparam int PULSE_MIN_NS = 50;
   localparam int SCLK_HALF_CYC =
      (SCLK_MIN_PERIOD_NS / 2 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int SETUP_CYC = (SETUP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int PULSE_CYC =
      (PULSE_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

   // Controller register map, byte addresses
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_PAR_VAL = 4'h4;
   localparam logic [3:0] REG_SER_VAL = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hc;
   localparam int CTRL_PAR_GO = 0;
   localparam int CTRL_SER_GO = 1;
   localparam int STAT_BUSY = 0;
   localparam int STAT_TEST = 1;
endpackage

// file: src/sdcl_if.sv
// Purpose: Configuration pins between controller and synthesizer
// Assumes: One system clock, pins sampled synchronously
// Notes: No clocking block; both ends are plain design modules
`timescale 1ns/1ps
`default_nettype none
interface sdcl_if;
   logic [8:0] loop_div;
   logic [1:0] out_div;
   logic par_load;
   logic shift_clock_alias;
   logic ser_data;
   logic ser_load;
   logic test_pin;
   logic [1:0] synth_output_pair;

   modport host (
      output loop_div, out_div, par_load, shift_clock_alias, ser_data,
      output ser_load,
      input test_pin, synth_output_pair
   );
   modport dev (
      input loop_div, out_div, par_load, shift_clock_alias, ser_data,
      input ser_load,
      output test_pin, synth_output_pair
   );
endinterface
`default_nettype wire

// file: src/sdcl_host.sv
// Purpose: Controller end that drives the configuration pins
// Assumes: Software port with read data one cycle after the strobe
// Notes: Shift clock kept at or below its loading limit
`timescale 1ns/1ps
`default_nettype none
module sdcl_host (
   input wire logic sys_clk_in,
   input wire logic srst_in,
   sdcl_if.host link,
   input wire logic [3:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_PAR_LOW = 3'h1,
      ST_PAR_HOLD = 3'h3,
      ST_SER_LO = 3'h2,
      ST_SER_HI = 3'h6,
      ST_SLOAD = 3'h7,
      ST_SLOAD_END = 3'h5
   } sdcl_host_state_e;

   sdcl_host_state_e state_q;
   logic [10:0] par_val_q;
   logic [13:0] ser_val_q;
   logic [13:0] out_shift_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] wait_q;
   logic [8:0] m_q;
   logic [1:0] n_q;
   logic pload_q;
   logic sclk_q;
   logic sdata_q;
   logic sload_q;
   logic busy;
   logic wait_done;
   logic go_par;
   logic go_ser;

   assign busy = state_q != ST_IDLE;
   assign wait_done = wait_q == 8'h00;
   assign go_par = wr_in && addr_in == sdcl_pkg::REG_CTRL &&
                   wdata_in[sdcl_pkg::CTRL_PAR_GO];
   assign go_ser = wr_in && addr_in == sdcl_pkg::REG_CTRL &&
                   wdata_in[sdcl_pkg::CTRL_SER_GO];

   // Value registers written by software
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         par_val_q <= {sdcl_pkg::N_RST, sdcl_pkg::M_RST};
         ser_val_q <= {sdcl_pkg::T_RST, sdcl_pkg::N_RST, sdcl_pkg::M_RST};
      end
      else if (wr_in && addr_in == sdcl_pkg::REG_PAR_VAL)
      begin
         par_val_q <= wdata_in[10:0];
      end
      else if (wr_in && addr_in == sdcl_pkg::REG_SER_VAL)
      begin
         ser_val_q <= wdata_in[13:0];
      end
   end

   // Read port; unmapped addresses read zero
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         rdata_out <= 32'h0000_0000;
      end
      else if (!rd_in)
      begin
         rdata_out <= 32'h0000_0000;
      end
      else if (addr_in == sdcl_pkg::REG_PAR_VAL)
      begin
         rdata_out <= {21'h00_0000, par_val_q};
      end
      else if (addr_in == sdcl_pkg::REG_SER_VAL)
      begin
         rdata_out <= {18'h0_0000, ser_val_q};
      end
      else if (addr_in == sdcl_pkg::REG_STATUS)
      begin
         rdata_out <= {30'h0000_0000, link.test_pin, busy};
      end
      else
      begin
         rdata_out <= 32'h0000_0000;
      end
   end

   // Load sequencer; the wait counter is the shift clock divider
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         state_q <= ST_IDLE;
         wait_q <= 8'h00;
         bit_cnt_q <= 4'h0;
         out_shift_q <= 14'h0000;
         m_q <= sdcl_pkg::M_RST;
         n_q <= sdcl_pkg::N_RST;
         pload_q <= 1'b1;
         sclk_q <= 1'b0;
         sdata_q <= 1'b0;
         sload_q <= 1'b0;
      end
      else if (!wait_done)
      begin
         wait_q <= wait_q - 8'h01;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
               if (go_par)
               begin
                  m_q <= par_val_q[8:0];
                  n_q <= par_val_q[10:9];
                  pload_q <= 1'b0;
                  wait_q <= 8'(sdcl_pkg::PULSE_CYC);
                  state_q <= ST_PAR_LOW;
               end
               else if (go_ser)
               begin
                  out_shift_q <= ser_val_q;
                  bit_cnt_q <= 4'(sdcl_pkg::SHIFT_LEN);
                  state_q <= ST_SER_LO;
               end
            ST_PAR_LOW:
            begin
               pload_q <= 1'b1;
               wait_q <= 8'(sdcl_pkg::SETUP_CYC);
               state_q <= ST_PAR_HOLD;
            end
            ST_PAR_HOLD:
               state_q <= ST_IDLE;
            ST_SER_LO:
            begin
               // Data set half a period ahead of the rising edge
               sdata_q <= out_shift_q[13];
               sclk_q <= 1'b0;
               wait_q <= 8'(sdcl_pkg::SCLK_HALF_CYC);
               state_q <= ST_SER_HI;
            end
            ST_SER_HI:
            begin
               sclk_q <= 1'b1;
               out_shift_q <= {out_shift_q[12:0], 1'b0};
               bit_cnt_q <= bit_cnt_q - 4'h1;
               wait_q <= 8'(sdcl_pkg::SCLK_HALF_CYC);
               state_q <= (bit_cnt_q == 4'h1) ? ST_SLOAD : ST_SER_LO;
            end
            ST_SLOAD:
            begin
               // Strobe only once every bit is in
               sclk_q <= 1'b0;
               sload_q <= 1'b1;
               wait_q <= 8'(sdcl_pkg::PULSE_CYC);
               state_q <= ST_SLOAD_END;
            end
            default:
            begin
               sload_q <= 1'b0;
               wait_q <= 8'(sdcl_pkg::SETUP_CYC);
               state_q <= ST_PAR_HOLD;
            end
         endcase
      end
   end

   // Pins straight from flip-flops
   assign link.loop_div = m_q;
   assign link.out_div = n_q;
   assign link.par_load = pload_q;
   assign link.shift_clock_alias = sclk_q;
   assign link.ser_data = sdata_q;
   assign link.ser_load = sload_q;
endmodule
`default_nettype wire

// file: verification/sdcl_chk.sv
// Purpose: Pin-level checks between controller and synthesizer
// Assumes: One clock, synchronous active-high reset
// Notes: Shadows the serial register from the wire itself
`timescale 1ns/1ps
`default_nettype none
module sdcl_chk (
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic [8:0] loop_div,
   input wire logic [1:0] out_div,
   input wire logic par_load,
   input wire logic shift_clock_alias,
   input wire logic ser_data,
   input wire logic ser_load,
   input wire logic test_pin,
   input wire logic [1:0] synth_output_pair
);
   logic [13:0] sh_q;
   logic [4:0] cnt_q;
   logic [2:0] t_q;
   default clocking @(posedge sys_clk_in);
   endclocking
   default disable iff (srst_in);

   // Shadow register, bit count and test bits seen on the wire
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         sh_q <= 14'h0000;
         cnt_q <= 5'h00;
         t_q <= 3'h0;
      end
      else
      begin
         if ($rose(shift_clock_alias) && par_load)
         begin
            sh_q <= {sh_q[12:0], ser_data};
            cnt_q <= cnt_q + 5'h01;
         end
         if ($fell(ser_load))
            cnt_q <= 5'h00;
         // Low parallel strobe wins over the serial strobe
         if (!par_load)
            t_q <= 3'h0;
         else if ($fell(ser_load))
            t_q <= sh_q[13:11];
      end
   end

   AST_PAR_WIDTH: assert property ($fell(par_load) |-> !par_load [*5])
      else $error("parallel strobe too short");
   AST_PAR_SETUP: assert property (
      $rose(par_load) |-> $stable({loop_div, out_div}))
      else $error("divider pins moved at strobe rise");
   AST_SCLK_HIGH: assert property (
      $rose(shift_clock_alias) |-> shift_clock_alias [*5])
      else $error("shift clock high phase too short");
   AST_SCLK_LOW: assert property (
      $fell(shift_clock_alias) |-> !shift_clock_alias [*5])
      else $error("shift clock low phase too short");
   AST_SER_PAR: assert property ($rose(shift_clock_alias) |-> par_load)
      else $error("shifting with parallel strobe low");
   AST_SLOAD_COUNT: assert property ($rose(ser_load) |-> cnt_q == 5'h0e)
      else $error("serial strobe before all bits shifted");
   AST_SLOAD_WIDTH: assert property ($rose(ser_load) |-> ser_load [*5])
      else $error("serial strobe too short");
   AST_PAIR_DIFF: assert property (
      synth_output_pair[1] != synth_output_pair[0])
      else $error("output pair not complementary");
   AST_FORCE_ZERO: assert property (
      !par_load && !$past(par_load) && !$past(par_load, 2) |->
      test_pin == sh_q[13])
      else $error("test pin not first shifted bit");
   AST_TEST_LEVEL: assert property (
      par_load && !ser_load && !$past(ser_load) && $past(t_q, 2) == t_q &&
      (t_q == 3'h1 || t_q == 3'h5) |-> test_pin == (t_q == 3'h1))
      else $error("static test level wrong");
   AST_TEST_PAIR: assert property (
      par_load && !ser_load && !$past(ser_load) && $past(t_q, 2) == t_q &&
      t_q == 3'h4 |-> test_pin == $past(synth_output_pair[0]))
      else $error("test pin not following output pair");
endmodule
`default_nettype wire

// file: verification/sdcl_bench.sv
// Purpose: Self-checking bench, host and device joined by pins
// Assumes: 100 MHz clock, synchronous reset held 8 cycles
// Notes: Bypass counts need any long loop modulus flushed first
`timescale 1ns/1ps
`default_nettype none
module sdcl_bench;
   logic sys_clk_in, srst_in, wr, rd, ref_clk, vco_tick, run_vco, byp;
   logic [3:0] addr;
   logic [31:0] wdata, rdata, rv;
   logic [8:0] cfg_m;
   logic [1:0] cfg_n;
   logic [2:0] cfg_t;
   logic [13:0] cap_q;
   logic sclk_d, pair_d, tst_d, lco, lco_d;
   int bad_count, n_compared, cycles, tog, rises, lrises;

   sdcl_if link ();
   sdcl_host i_sdcl_host (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
      .link(link), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
      .rd_in(rd), .rdata_out(rdata));
   sdcl_device i_sdcl_device (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
      .link(link), .reference_input_clock_in(ref_clk),
      .vco_tick_in(vco_tick), .cfg_loop_out(cfg_m), .cfg_out_div_out(cfg_n),
      .cfg_test_out(cfg_t), .bypass_out(byp), .loop_counter_output_out(lco));
   sdcl_chk i_sdcl_chk (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
      .loop_div(link.loop_div), .out_div(link.out_div),
      .par_load(link.par_load), .shift_clock_alias(link.shift_clock_alias),
      .ser_data(link.ser_data), .ser_load(link.ser_load),
      .test_pin(link.test_pin), .synth_output_pair(link.synth_output_pair));

   // Free-running system clock
   initial
   begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end

   // Random reference and loop ticks; ticks halt for bypass counts
   always @(posedge sys_clk_in)
   begin
      ref_clk <= 1'($urandom);
      vco_tick <= run_vco & 1'($urandom);
   end

   // Wire monitor: serial capture, bypass edges, watchdog
   always @(posedge sys_clk_in)
   begin
      sclk_d <= link.shift_clock_alias;
      pair_d <= link.synth_output_pair[0];
      tst_d <= link.test_pin;
      if (link.shift_clock_alias && !sclk_d && link.par_load)
         cap_q <= {cap_q[12:0], link.ser_data};
      if (pair_d !== link.synth_output_pair[0])
         tog <= tog + 1;
      if (link.test_pin && !tst_d)
         rises <= rises + 1;
      lco_d <= lco;
      if (lco && !lco_d)
         lrises <= lrises + 1;
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         bad_count++;
         results();
      end
   end

   task automatic chk(input string what, input logic [31:0] e,
      input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask

   // Bus cycles start one edge later so strobes never double-assign
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk_in);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
      @(posedge sys_clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk_in);
      rd <= 1'b0;
      @(negedge sys_clk_in);
      v = rdata;
   endtask

   task automatic wait_idle(output logic [31:0] v);
      v = 32'h0000_0001;
      for (int i = 0; i < 120 && v[0] !== 1'b0; i++)
         rd_reg(sdcl_pkg::REG_STATUS, v);
   endtask

   // Level expected on the test pin for the static selections
   function automatic logic exp_pin(input logic [2:0] t);
      return (t == 3'h0) ? t[2] : (t == 3'h1);
   endfunction

   // Divider ticks over one full serial load, divided by a modulus
   function automatic int edges(input int d);
      return 2 * sdcl_pkg::SHIFT_LEN / d;
   endfunction

   task automatic par_do(input logic [8:0] m, input logic [1:0] n);
      wr_reg(sdcl_pkg::REG_PAR_VAL, 32'({n, m}));
      wr_reg(sdcl_pkg::REG_CTRL, 32'h0000_0001);
      repeat (3) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      chk("open latch", 32'(m), 32'(cfg_m));
      wait_idle(rv);
      chk("busy", 32'h0000_0000, 32'(rv[0]));
      chk("loop div", 32'(m), 32'(cfg_m));
      chk("out div", 32'(n), 32'(cfg_n));
      chk("test bits", 32'h0000_0000, 32'(cfg_t));
      rd_reg(sdcl_pkg::REG_PAR_VAL, rv);
      chk("par val", 32'({n, m}), rv);
   endtask

   // Clash issues a parallel go while the serial load is busy
   task automatic ser_do(input logic [2:0] t, input logic [1:0] n,
      input logic [8:0] m, input logic clash);
      wr_reg(sdcl_pkg::REG_SER_VAL, 32'({t, n, m}));
      wr_reg(sdcl_pkg::REG_CTRL, 32'h0000_0002);
      if (clash)
         wr_reg(sdcl_pkg::REG_CTRL, 32'h0000_0001);
      wait_idle(rv);
      chk("busy", 32'h0000_0000, 32'(rv[0]));
      chk("wire bits", 32'({t, n, m}), 32'(cap_q));
      chk("loop div", 32'(m), 32'(cfg_m));
      chk("out div", 32'(n), 32'(cfg_n));
      chk("test bits", 32'(t), 32'(cfg_t));
      chk("bypass", 32'(t == 3'h6), 32'(byp));
      if (t == 3'h0 || t == 3'h1 || t == 3'h5)
         chk("status test", 32'(exp_pin(t)), 32'(rv[1]));
      rd_reg(sdcl_pkg::REG_SER_VAL, rv);
      chk("ser val", 32'({t, n, m}), rv);
   endtask

   task automatic results();
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Main sequence: reset, bus corners, loads, bypass counts
   initial
   begin
      srst_in = 1'b1;
      addr = 4'h0;
      wdata = 32'h0000_0000;
      wr = 1'b0;
      rd = 1'b0;
      run_vco = 1'b1;
      ref_clk = 1'b0;
      vco_tick = 1'b0;
      {sclk_d, pair_d, tst_d, lco_d} = 4'h0;
      cap_q = 14'h0000;
      {bad_count, n_compared, cycles, tog, rises, lrises} = '0;
      void'($urandom(32'hc296_9a4a));
      repeat (8) @(posedge sys_clk_in);
      srst_in <= 1'b0;
      @(negedge sys_clk_in);
      chk("reset test bits", 32'h0000_0000, 32'(cfg_t));
      chk("reset pair", 32'h0000_0002, 32'(link.synth_output_pair));
      rd_reg(4'h2, rv);
      chk("unmapped read", 32'h0000_0000, rv);
      rd_reg(sdcl_pkg::REG_CTRL, rv);
      chk("ctrl read", 32'h0000_0000, rv);
      par_do(9'h000, 2'h0);
      par_do(9'h1ff, 2'h3);
      repeat (4) par_do(9'($urandom), 2'($urandom));
      for (int t = 0; t < 8; t++)
         ser_do(3'(t), 2'($urandom), 9'($urandom), 1'(t == 0));
      // Let any long loop modulus wrap before counting bypass edges
      par_do(9'h002, 2'h3);
      repeat (1500) @(posedge sys_clk_in);
      run_vco <= 1'b0;
      ser_do(3'h6, 2'h3, 9'h002, 1'b0);
      tog = 0;
      rises = 0;
      lrises = 0;
      ser_do(3'h6, 2'h3, 9'h002, 1'b0);
      chk("bypass pair edges", 32'(edges(1)), 32'(tog));
      chk("bypass loop pulses", 32'(edges(2)), 32'(rises));
      chk("loop out pulses", 32'(edges(2)), 32'(lrises));
      run_vco <= 1'b1;
      par_do(9'($urandom), 2'($urandom));
      results();
   end
endmodule
`default_nettype wire
